/* File: design/pnpp_port.sv */
// Purpose: device side of the parallel nonvolatile programming port
// Assumes: pins asynchronous, pulses much longer than two CLK periods
// Notes: memories have no reset; flash reads unknown until erased
module pnpp_port #(
	parameter int PAGE_CYCLES = pnpp_pkg::PAGE_PROG_CYCLES,
	parameter int ERASE_CYCLES = pnpp_pkg::ERASE_CYCLES,
	// identification and trim values are arbitrary
	parameter logic [7:0] ID_BYTE0 = 8'h5A,
	parameter logic [7:0] ID_BYTE1 = 8'h3C,
	parameter logic [7:0] ID_BYTE2 = 8'h01,
	parameter logic [7:0] TRIM_1MHZ = 8'h80,
	parameter logic [7:0] TRIM_2MHZ = 8'h81,
	parameter logic [7:0] TRIM_4MHZ = 8'h82,
	parameter logic [7:0] TRIM_8MHZ = 8'h83
) (
	// clock and reset
	input wire logic CLK,
	input wire logic RST_B,
	// programming pins
	input wire pnpp_pkg::pnpp_pins_s PINS,
	output logic [7:0] DATA_OUT,
	output logic DATA_OE,
	output logic PROG_READY_FLAG,
	output logic PROG_MODE,
	// trim register
	input wire logic TRIM_WR_EN,
	input wire logic [7:0] TRIM_WR_DATA,
	output logic [7:0] RC_TRIM_REGISTER,
	// fuse and lock state
	output logic [7:0] FUSE_LOW_ACTIVE,
	output logic [7:0] FUSE_HIGH_ACTIVE,
	output logic [7:0] LOCK_BITS
);
	import pnpp_pkg::*;

	localparam logic [TIMER_W-1:0] PAGE_LOAD = TIMER_W'(PAGE_CYCLES - 1);
	localparam logic [TIMER_W-1:0] ERASE_LOAD = TIMER_W'(ERASE_CYCLES - 1);
	localparam logic [3:0] ENTRY_LAST = 4'(ENTRY_CYCLES - 1);
	pnpp_state_s st;
	pnpp_state_s next_st;
	pnpp_pins_s p;
	logic [15:0] flash_mem [FLASH_WORDS];
	logic [7:0] ee_mem [EE_BYTES];
	logic [15:0] word_buf [PAGE_WORDS];
	logic [7:0] ee_buf [EE_PAGE_BYTES];
	logic strobe_rise, page_latch_strobe_rise, wr_fall, hv_rise;
	logic [1:0] action;
	logic [3:0] entry_pins;
	logic [15:0] addr;
	logic [FLASH_AW-1:0] flash_addr;
	logic [EE_AW-1:0] ee_addr;
	logic latch_word, latch_ee, commit_page, commit_ee, erase_flash_we, erase_ee_we;
	logic keep_ee;
	logic [7:0] read_byte;

	// ==========================================
	// pin synchronisers
	pnpp_sync #(
		.WIDTH($bits(pnpp_pins_s))
	) u_sync (
		.clk(CLK),
		.rst_b(RST_B),
		.d(PINS),
		.q(p)
	);

	// ==========================================
	// edges and decode
	assign strobe_rise = p.load_strobe && !st.strobe_q;
	assign page_latch_strobe_rise = p.page_latch_strobe && !st.page_latch_strobe_q;
	assign wr_fall = !p.wr_b && st.wr_q;
	assign hv_rise = p.hv_present && !st.hv_q;
	assign action = {p.strobe_action_bit1, p.strobe_action_bit0};
	assign entry_pins = {p.page_latch_strobe, action, p.byte_select_first};
	assign addr = {st.addr_hi, st.addr_lo};
	// page bits come from the top of the low address byte and the bottom of the high byte
	assign flash_addr = addr[FLASH_AW-1:0];
	assign ee_addr = addr[EE_AW-1:0];
	// keep fuse acts on its stored value, not the latched one
	assign keep_ee = !st.fuse_high[KEEP_FUSE_BIT];

	// ==========================================
	// read mux
	always_comb begin
		read_byte = 8'h00;
		unique case (st.cmd)
			CMD_RD_SIG: begin
				// identification row ignores lock bits
				unique case ({p.byte_select_first, st.addr_lo[1:0]})
					3'h0: read_byte = ID_BYTE0;
					3'h1: read_byte = ID_BYTE1;
					3'h2: read_byte = ID_BYTE2;
					3'h4: read_byte = TRIM_1MHZ;
					3'h5: read_byte = TRIM_2MHZ;
					3'h6: read_byte = TRIM_4MHZ;
					3'h7: read_byte = TRIM_8MHZ;
					default: read_byte = 8'h00;
				endcase
			end
			CMD_RD_FUSE: begin
				unique case ({p.byte_select_second, p.byte_select_first})
					2'h0: read_byte = st.fuse_low;
					2'h3: read_byte = st.fuse_high;
					2'h1: read_byte = st.lock;
					default: read_byte = 8'h00;
				endcase
			end
			CMD_RD_FLASH: begin
				if (p.byte_select_first) begin
					read_byte = flash_mem[flash_addr][15:8];
				end else begin
					read_byte = flash_mem[flash_addr][7:0];
				end
			end
			CMD_RD_EE: read_byte = ee_mem[ee_addr];
			default: read_byte = 8'h00;
		endcase
	end

	// ==========================================
	// next state
	always_comb begin
		next_st = st;
		latch_word = 1'b0;
		latch_ee = 1'b0;
		commit_page = 1'b0;
		commit_ee = 1'b0;
		erase_flash_we = 1'b0;
		erase_ee_we = 1'b0;
		next_st.strobe_q = p.load_strobe;
		next_st.page_latch_strobe_q = p.page_latch_strobe;
		next_st.wr_q = p.wr_b;
		next_st.hv_q = p.hv_present;
		if (TRIM_WR_EN) begin
			next_st.trim = TRIM_WR_DATA;
		end
		if (st.timer != '0) begin
			next_st.timer = st.timer - TIMER_W'(1);
		end
		unique case (st.mode)
			M_OUT: begin
				if (hv_rise) begin
					next_st.entry_cnt = '0;
					next_st.mode = (entry_pins == 4'h0) ? M_ENTRY : M_FAIL;
				end
			end
			M_ENTRY: begin
				if (entry_pins != 4'h0) begin
					next_st.mode = M_FAIL;
				end else if (st.entry_cnt == ENTRY_LAST) begin
					next_st.mode = M_IDLE;
					next_st.fuse_low_act = st.fuse_low;
					next_st.fuse_high_act = st.fuse_high;
				end else begin
					next_st.entry_cnt = st.entry_cnt + 4'h1;
				end
			end
			M_FAIL: begin
			end
			M_IDLE: begin
				if (strobe_rise) begin
					unique case (action)
						ACT_ADDR: begin
							if (p.byte_select_second) begin
								next_st.addr_ext = p.data;
							end else if (p.byte_select_first) begin
								next_st.addr_hi = p.data;
							end else begin
								next_st.addr_lo = p.data;
							end
						end
						ACT_DATA: begin
							if (p.byte_select_first) begin
								next_st.data_hi = p.data;
							end else begin
								next_st.data_lo = p.data;
							end
						end
						ACT_CMD: begin
							next_st.cmd = p.data;
							if (p.data == CMD_NOP) begin
								next_st.word_mask = '0;
								next_st.ee_mask = '0;
							end
						end
						default: begin
						end
					endcase
				end
				if (page_latch_strobe_rise) begin
					if (st.cmd == CMD_WR_FLASH && p.byte_select_first) begin
						latch_word = 1'b1;
						next_st.word_mask[st.addr_lo[WORD_AW-1:0]] = 1'b1;
					end else if (st.cmd == CMD_WR_EE) begin
						latch_ee = 1'b1;
						next_st.ee_mask[st.addr_lo[EE_BYTE_AW-1:0]] = 1'b1;
					end
				end
				if (wr_fall) begin
					unique case (st.cmd)
						CMD_ERASE: begin
							next_st.sweep = '0;
							next_st.timer = ERASE_LOAD;
							next_st.mode = M_ERASE_FLASH;
						end
						CMD_WR_FLASH: begin
							if (!p.byte_select_first) begin
								commit_page = 1'b1;
								next_st.word_mask = '0;
								next_st.timer = PAGE_LOAD;
								next_st.mode = M_WAIT;
							end
						end
						CMD_WR_EE: begin
							if (!p.byte_select_first) begin
								commit_ee = 1'b1;
								next_st.ee_mask = '0;
								next_st.timer = PAGE_LOAD;
								next_st.mode = M_WAIT;
							end
						end
						CMD_WR_FUSE: begin
							// fuses stay frozen once lock bit zero is programmed
							if (st.lock[LOCK_FUSE_BIT]) begin
								if (p.byte_select_first) begin
									next_st.fuse_high = st.data_lo;
								end else begin
									next_st.fuse_low = st.data_lo;
								end
							end
							next_st.timer = PAGE_LOAD;
							next_st.mode = M_WAIT;
						end
						CMD_WR_LOCK: begin
							// only programming; clearing needs an erase
							next_st.lock = st.lock & st.data_lo;
							next_st.timer = PAGE_LOAD;
							next_st.mode = M_WAIT;
						end
						default: begin
						end
					endcase
				end
			end
			M_ERASE_FLASH: begin
				erase_flash_we = 1'b1;
				next_st.sweep = st.sweep + FLASH_AW'(1);
				if (st.sweep == FLASH_AW'(FLASH_WORDS - 1)) begin
					if (keep_ee) begin
						next_st.lock = LOCK_RST;
						next_st.mode = M_WAIT;
					end else begin
						next_st.mode = M_ERASE_EE;
					end
				end
			end
			M_ERASE_EE: begin
				erase_ee_we = 1'b1;
				next_st.sweep = st.sweep + FLASH_AW'(1);
				if (st.sweep == FLASH_AW'(EE_BYTES - 1)) begin
					next_st.lock = LOCK_RST;
					next_st.mode = M_WAIT;
				end
			end
			M_WAIT: begin
				if (st.timer == '0) begin
					next_st.mode = M_IDLE;
				end
			end
		endcase
		// losing the high voltage ends programming from any state
		if (!p.hv_present) begin
			next_st.mode = M_OUT;
		end
		next_st.prog = !(next_st.mode inside {M_OUT, M_ENTRY, M_FAIL});
		next_st.ready = next_st.mode == M_IDLE;
		next_st.doe = next_st.prog && !p.oe_b;
		next_st.dout = read_byte;
	end

	// ==========================================
	// state register
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			st <= '0; // edge history matches the synchroniser reset level
			st.fuse_low <= FUSE_LOW_RST;
			st.fuse_high <= FUSE_HIGH_RST;
			st.fuse_low_act <= FUSE_LOW_RST;
			st.fuse_high_act <= FUSE_HIGH_RST;
			st.lock <= LOCK_RST;
			st.trim <= TRIM_1MHZ;
		end else begin
			st <= next_st;
		end
	end

	// ==========================================
	// memories and page buffers
	always_ff @(posedge CLK) begin
		if (latch_word) begin
			word_buf[st.addr_lo[WORD_AW-1:0]] <= {st.data_hi, st.data_lo};
		end
		if (latch_ee) begin
			ee_buf[st.addr_lo[EE_BYTE_AW-1:0]] <= st.data_lo;
		end
		if (commit_page) begin
			for (int i = 0; i < PAGE_WORDS; i++) begin
				if (st.word_mask[i]) begin
					flash_mem[{flash_addr[FLASH_AW-1:WORD_AW], WORD_AW'(i)}] <= word_buf[i];
				end
			end
		end
		if (commit_ee) begin
			for (int j = 0; j < EE_PAGE_BYTES; j++) begin
				if (st.ee_mask[j]) begin
					ee_mem[{ee_addr[EE_AW-1:EE_BYTE_AW], EE_BYTE_AW'(j)}] <= ee_buf[j];
				end
			end
		end
		if (erase_flash_we) begin
			flash_mem[st.sweep] <= ERASED_WORD;
		end
		if (erase_ee_we) begin
			ee_mem[st.sweep[EE_AW-1:0]] <= ERASED_BYTE;
		end
	end

	// ==========================================
	// outputs
	assign DATA_OUT = st.dout;
	assign DATA_OE = st.doe;
	assign PROG_READY_FLAG = st.ready;
	assign PROG_MODE = st.prog;
	assign RC_TRIM_REGISTER = st.trim;
	assign FUSE_LOW_ACTIVE = st.fuse_low_act;
	assign FUSE_HIGH_ACTIVE = st.fuse_high_act;
	assign LOCK_BITS = st.lock;

	// ==========================================
	// checks
	a_bus_release: assert property (@(posedge CLK) disable iff (!RST_B)
		p.oe_b |=> !DATA_OE) else $error("data bus driven with output enable high");
	a_bus_drive: assert property (@(posedge CLK) disable iff (!RST_B)
		(st.prog && p.hv_present && !p.oe_b && $stable(st.mode)) |=> DATA_OE)
		else $error("data bus not driven during read");
	a_page_busy: assert property (@(posedge CLK) disable iff (!RST_B)
		commit_page |=> (!PROG_READY_FLAG)[*8]) else $error("ready high during page write");
	a_cmd_load: assert property (@(posedge CLK) disable iff (!RST_B)
		(st.mode == M_IDLE && strobe_rise && action == ACT_CMD && p.hv_present)
		|=> st.cmd == $past(p.data)) else $error("command not loaded");
	a_idle_action: assert property (@(posedge CLK) disable iff (!RST_B)
		(strobe_rise && action == 2'h3) |=> ($stable(st.cmd) && $stable(addr)))
		else $error("idle action changed command or address");
	a_nop_clear: assert property (@(posedge CLK) disable iff (!RST_B)
		(st.mode == M_IDLE && strobe_rise && action == ACT_CMD && p.data == CMD_NOP)
		|=> (st.word_mask == '0 && st.ee_mask == '0)) else $error("nop left buffer state");
	a_lock_hold: assert property (@(posedge CLK) disable iff (!RST_B)
		(st.mode == M_ERASE_FLASH && $past(st.mode) == M_ERASE_FLASH) |-> $stable(st.lock))
		else $error("locks cleared before flash erased");
	a_entry_fail: assert property (@(posedge CLK) disable iff (!RST_B)
		(st.mode == M_OUT && hv_rise && entry_pins != 4'h0) |=> st.mode == M_FAIL ##1 !PROG_MODE)
		else $error("entered programming with wrong entry pins");
	a_trim_keep: assert property (@(posedge CLK) disable iff (!RST_B)
		!TRIM_WR_EN |=> $stable(RC_TRIM_REGISTER)) else $error("trim changed without write");

endmodule

/* File: design/pnpp_pkg.sv */
// Purpose: shared constants and types of the parallel programming port
// Assumes: 10 MHz CLK, all programming pins asynchronous to CLK
// Notes: fuse and lock reset values are factory defaults
package pnpp_pkg;

	// ==========================================
	// timing
	localparam int CLK_MHZ = 10;
	localparam int ENTRY_HOLD_NS = 100;
	localparam int ENTRY_CYCLES = (ENTRY_HOLD_NS * CLK_MHZ + 999) / 1000;
	localparam int PAGE_PROG_US = 4000;
	localparam int PAGE_PROG_CYCLES = PAGE_PROG_US * CLK_MHZ;
	localparam int ERASE_US = 8000;
	localparam int ERASE_CYCLES = ERASE_US * CLK_MHZ;
	localparam int TIMER_W = 20;

	// ==========================================
	// memory geometry
	localparam int FLASH_AW = 13;
	localparam int WORD_AW = 6;
	localparam int EE_AW = 9;
	localparam int EE_BYTE_AW = 2;
	localparam int FLASH_WORDS = 8192;
	localparam int PAGE_WORDS = 64;
	localparam int EE_BYTES = 512;
	localparam int EE_PAGE_BYTES = 4;

	// ==========================================
	// action codes and commands
	localparam logic [1:0] ACT_ADDR = 2'h0;
	localparam logic [1:0] ACT_DATA = 2'h1;
	localparam logic [1:0] ACT_CMD = 2'h2;
	localparam logic [7:0] CMD_NOP = 8'h00;
	localparam logic [7:0] CMD_ERASE = 8'h80;
	localparam logic [7:0] CMD_WR_FUSE = 8'h40;
	localparam logic [7:0] CMD_WR_LOCK = 8'h20;
	localparam logic [7:0] CMD_WR_FLASH = 8'h10;
	localparam logic [7:0] CMD_WR_EE = 8'h11;
	localparam logic [7:0] CMD_RD_SIG = 8'h08;
	localparam logic [7:0] CMD_RD_FUSE = 8'h04;
	localparam logic [7:0] CMD_RD_FLASH = 8'h02;
	localparam logic [7:0] CMD_RD_EE = 8'h03;

	// ==========================================
	// reset values and fields
	localparam logic [7:0] FUSE_LOW_RST = 8'hE1;
	localparam logic [7:0] FUSE_HIGH_RST = 8'h99;
	localparam logic [7:0] LOCK_RST = 8'hFF;
	localparam int KEEP_FUSE_BIT = 3;
	localparam int LOCK_FUSE_BIT = 0;
	localparam logic [15:0] ERASED_WORD = 16'hFFFF;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;

	// ==========================================
	// types
	typedef struct packed {
		logic load_strobe;
		logic page_latch_strobe;
		logic strobe_action_bit1;
		logic strobe_action_bit0;
		logic byte_select_first;
		logic byte_select_second;
		logic wr_b;
		logic oe_b;
		logic hv_present;
		logic [7:0] data;
	} pnpp_pins_s;

	typedef enum logic [2:0] {
		M_OUT, M_ENTRY, M_FAIL, M_IDLE, M_ERASE_FLASH, M_ERASE_EE, M_WAIT
	} pnpp_mode_e;

	typedef struct packed {
		pnpp_mode_e mode;
		logic strobe_q;
		logic page_latch_strobe_q;
		logic wr_q;
		logic hv_q;
		logic [7:0] cmd;
		logic [7:0] addr_lo;
		logic [7:0] addr_hi;
		logic [7:0] addr_ext;
		logic [7:0] data_lo;
		logic [7:0] data_hi;
		logic [PAGE_WORDS-1:0] word_mask;
		logic [EE_PAGE_BYTES-1:0] ee_mask;
		logic [TIMER_W-1:0] timer;
		logic [FLASH_AW-1:0] sweep;
		logic [3:0] entry_cnt;
		logic [7:0] fuse_low;
		logic [7:0] fuse_high;
		logic [7:0] lock;
		logic [7:0] fuse_low_act;
		logic [7:0] fuse_high_act;
		logic [7:0] trim;
		logic ready;
		logic prog;
		logic [7:0] dout;
		logic doe;
	} pnpp_state_s;

endpackage

/* File: design/pnpp_sync.sv */
// Purpose: two-flop synchroniser for a group of pins
// Assumes: each bit is an independent level
// Notes: multi-bit words may skew by a cycle; strobes qualify them
module pnpp_sync #(
	parameter int WIDTH = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// levels
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);

	logic [WIDTH-1:0] meta;

	// ==========================================
	// one pair of flops per bit
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_bit
			always_ff @(posedge clk or negedge rst_b) begin
				if (!rst_b) begin
					meta[g] <= 1'b0;
					q[g] <= 1'b0;
				end else begin
					meta[g] <= d[g];
					q[g] <= meta[g];
				end
			end
		end
	endgenerate

endmodule

/* File: sim/pnpp_prog_model.sv */
// Purpose: external parallel programmer driving the programming pins
// Assumes: every pin change lands on a falling CLK edge
// Notes: each level is held at least four CLK periods, well over the two-flop sync delay
module pnpp_prog_model (
	// clock
	input wire logic clk,
	// pins toward the device
	output pnpp_pkg::pnpp_pins_s pins,
	input wire logic [7:0] data_out,
	input wire logic data_oe
);
	import pnpp_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;

	pnpp_pins_s drv;

	// ==========================================
	// shared data bus
	// released bus shows the inverse, so a stale byte never reads as valid
	always_comb begin
		pins = drv;
		pins.data = data_oe ? data_out : (drv.oe_b ? drv.data : ~drv.data);
	end

	initial begin
		drv = '0;
		drv.wr_b = 1'b1;
		drv.oe_b = 1'b1;
	end

	// ==========================================
	// pin cycles
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic load(input logic [1:0] act, input logic bs1, input logic bs2,
		input logic [7:0] d);
		drv.strobe_action_bit1 = act[1];
		drv.strobe_action_bit0 = act[0];
		drv.byte_select_first = bs1;
		drv.byte_select_second = bs2;
		drv.data = d;
		cyc(4);
		drv.load_strobe = 1'b1;
		cyc(4);
		drv.load_strobe = 1'b0;
		cyc(4);
	endtask

	task automatic latch(input logic bs1);
		drv.byte_select_first = bs1;
		cyc(4);
		drv.page_latch_strobe = 1'b1;
		cyc(4);
		drv.page_latch_strobe = 1'b0;
		cyc(4);
	endtask

	// returns with the strobe released; caller then waits for ready
	task automatic wpulse(input logic bs1);
		drv.byte_select_first = bs1;
		cyc(4);
		drv.wr_b = 1'b0;
		cyc(6);
		drv.wr_b = 1'b1;
	endtask

	task automatic rd(input logic bs1, input logic bs2, output logic [7:0] v,
		output logic oe);
		drv.byte_select_first = bs1;
		drv.byte_select_second = bs2;
		drv.oe_b = 1'b0;
		cyc(6);
		v = pins.data;
		oe = data_oe;
		drv.oe_b = 1'b1;
		cyc(4);
	endtask

	// ==========================================
	// mode entry and exit
	task automatic enter(input logic bs1);
		drv = '0;
		drv.wr_b = 1'b1;
		drv.oe_b = 1'b1;
		drv.byte_select_first = bs1;
		repeat (6) begin
			cyc(4);
			drv.load_strobe = 1'b1;
			cyc(4);
			drv.load_strobe = 1'b0;
		end
		cyc(4);
		drv.hv_present = 1'b1;
		cyc(8);
	endtask

	task automatic leave();
		drv.hv_present = 1'b0;
		cyc(6);
	endtask
endmodule

/* File: sim/tb.sv */
// Purpose: self-checking bench of the programming port
// Assumes: short page and erase counts so the run stays brief
// Notes: memories are erased before any flash or eeprom read
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import pnpp_pkg::*;

	// arbitrary identification and trim values
	localparam logic [23:0] IDV = 24'h2B_4D_6E;
	localparam logic [31:0] TRV = 32'h93_92_91_90;
	localparam logic [31:0] FA = 32'h41_7F_40_42;
	localparam logic [63:0] FW = 64'h1234_BEEF_FFFF_FFFF;

	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic trim_wr_en = 1'b0;
	logic [7:0] trim_wr_data = 8'h00;
	pnpp_pins_s pins;
	logic [7:0] data_out, trim, fuse_lo, fuse_hi, lock;
	logic data_oe, ready, prog_mode;
	int n_fail = 0;
	int tests_run = 0;
	int i;
	logic [15:0] w;

	always #50 clk = ~clk;

	pnpp_port #(.PAGE_CYCLES(16), .ERASE_CYCLES(9000), .ID_BYTE0(IDV[7:0]),
		.ID_BYTE1(IDV[15:8]), .ID_BYTE2(IDV[23:16]), .TRIM_1MHZ(TRV[7:0]),
		.TRIM_2MHZ(TRV[15:8]), .TRIM_4MHZ(TRV[23:16]), .TRIM_8MHZ(TRV[31:24])) uut (
		.CLK(clk), .RST_B(rst_b), .PINS(pins), .DATA_OUT(data_out), .DATA_OE(data_oe),
		.PROG_READY_FLAG(ready), .PROG_MODE(prog_mode), .TRIM_WR_EN(trim_wr_en),
		.TRIM_WR_DATA(trim_wr_data), .RC_TRIM_REGISTER(trim), .FUSE_LOW_ACTIVE(fuse_lo),
		.FUSE_HIGH_ACTIVE(fuse_hi), .LOCK_BITS(lock));

	pnpp_prog_model prog (.clk(clk), .pins(pins), .data_out(data_out), .data_oe(data_oe));

	// ==========================================
	// checks and closing
	task automatic conclude();
		$display("checks %0d, mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic chk1(input logic got, input logic exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic rdchk(input logic bs1, input logic bs2, input logic [7:0] exp);
		logic [7:0] v;
		logic oe;
		prog.rd(bs1, bs2, v, oe);
		chk8(v, exp);
		chk1(oe, 1'b1);
	endtask

	// write strobe, busy seen, then a bounded wait for ready
	task automatic fire(input int max);
		int n = 0;
		prog.wpulse(1'b0);
		chk1(ready, 1'b0);
		while (ready !== 1'b1 && n < max) begin
			@(negedge clk);
			n++;
		end
		if (ready !== 1'b1) begin
			n_fail++;
			$display("ERROR t=%0t got %h exp %h", $time, ready, 1'b1);
			conclude();
		end
	endtask

	task automatic flw(input logic [7:0] a, input logic [15:0] d);
		prog.load(ACT_ADDR, 1'b0, 1'b0, a);
		prog.load(ACT_DATA, 1'b0, 1'b0, d[7:0]);
		prog.load(ACT_DATA, 1'b1, 1'b0, d[15:8]);
		prog.latch(1'b1);
	endtask

	initial begin
		repeat (100000) @(posedge clk);
		n_fail++;
		conclude();
	end

	// ==========================================
	// main sequence
	initial begin
		repeat (20) @(negedge clk);
		chk8(trim, TRV[7:0]);
		chk1(prog_mode, 1'b0);
		chk8(lock, LOCK_RST);
		rst_b = 1'b1;
		repeat (4) @(negedge clk);
		trim_wr_en = 1'b1;
		trim_wr_data = 8'h3E;
		@(negedge clk);
		trim_wr_en = 1'b0;
		@(negedge clk);
		chk8(trim, 8'h3E);
		prog.enter(1'b0);
		chk1(prog_mode, 1'b1);
		chk1(ready, 1'b1);
		chk8(fuse_lo, FUSE_LOW_RST);
		prog.load(ACT_CMD, 1'b0, 1'b0, CMD_WR_FUSE);
		prog.load(ACT_DATA, 1'b0, 1'b0, 8'hE2);
		fire(100);
		chk8(fuse_lo, FUSE_LOW_RST);
		prog.load(ACT_CMD, 1'b0, 1'b0, CMD_WR_LOCK);
		prog.load(ACT_DATA, 1'b0, 1'b0, 8'hFC);
		fire(100);
		chk8(lock, 8'hFC);
		// locked part still shows identification and trim
		prog.load(ACT_CMD, 1'b0, 1'b0, CMD_RD_SIG);
		for (i = 0; i < 4; i++) begin
			prog.load(ACT_ADDR, 1'b0, 1'b0, 8'(i));
			if (i < 3) rdchk(1'b0, 1'b0, IDV[8*i +: 8]);
			rdchk(1'b1, 1'b0, TRV[8*i +: 8]);
		end
		prog.load(ACT_CMD, 1'b0, 1'b0, CMD_RD_FUSE);
		rdchk(1'b0, 1'b0, 8'hE2);
		rdchk(1'b1, 1'b1, FUSE_HIGH_RST);
		rdchk(1'b1, 1'b0, 8'hFC);
		chk1(data_oe, 1'b0);
		prog.load(ACT_CMD, 1'b0, 1'b0, CMD_ERASE);
		fire(12000);
		chk8(lock, LOCK_RST);
		prog.load(ACT_CMD, 1'b0, 1'b0, CMD_WR_FLASH);
		prog.load(ACT_ADDR, 1'b1, 1'b0, 8'h00);
		flw(8'h41, 16'h1234);
		flw(8'h7F, 16'hBEEF);
		fire(100);
		// a buffered word is dropped by the no-operation command
		flw(8'h42, 16'h5555);
		prog.load(ACT_CMD, 1'b0, 1'b0, CMD_NOP);
		prog.load(ACT_CMD, 1'b0, 1'b0, CMD_WR_FLASH);
		fire(100);
		prog.load(ACT_CMD, 1'b0, 1'b0, CMD_RD_FLASH);
		for (i = 0; i < 4; i++) begin
			w = FW[63-16*i -: 16];
			prog.load(ACT_ADDR, 1'b0, 1'b0, FA[31-8*i -: 8]);
			rdchk(1'b0, 1'b0, w[7:0]);
			rdchk(1'b1, 1'b0, w[15:8]);
		end
		prog.load(ACT_ADDR, 1'b0, 1'b0, 8'h41);
		prog.load(2'h3, 1'b0, 1'b0, 8'h7F);
		rdchk(1'b0, 1'b0, 8'h34);
		prog.load(ACT_CMD, 1'b0, 1'b0, CMD_WR_EE);
		prog.load(ACT_ADDR, 1'b0, 1'b0, 8'h05);
		prog.load(ACT_DATA, 1'b0, 1'b0, 8'hA7);
		prog.latch(1'b0);
		fire(100);
		prog.load(ACT_CMD, 1'b0, 1'b0, CMD_RD_EE);
		rdchk(1'b0, 1'b0, 8'hA7);
		prog.load(ACT_ADDR, 1'b0, 1'b0, 8'h04);
		rdchk(1'b0, 1'b0, ERASED_BYTE);
		// new fuse value takes effect only on the next entry
		prog.leave();
		chk1(prog_mode, 1'b0);
		chk1(ready, 1'b0);
		// a select held high at voltage rise must refuse entry
		prog.enter(1'b1);
		chk1(prog_mode, 1'b0);
		chk1(ready, 1'b0);
		prog.leave();
		prog.enter(1'b0);
		chk1(prog_mode, 1'b1);
		chk8(fuse_lo, 8'hE2);
		chk8(fuse_hi, FUSE_HIGH_RST);
		conclude();
	end
endmodule
